// ==== hdl/ccpt_top.v ====
// Period timer with postscaler plus capture/compare unit and registers
// Assumes a synchronous register port, an external Timer1 counter and
// a pin level that may be asynchronous, synchronised at i_clk's domain boundary
`timescale 1ns/100ps
`include "ccpt_map.vh"

// Function
// - 8-bit timer, prescale 1, 4 or 16
// - Count from zero, wrap after limit match
// - Period limit register, resets to all ones
// - Count register read/write, cleared by reset
// - Postscaler divides matches, sets period flag
// - Run bit starts and stops counting
// - Count or control write clears scalers
// - Control write keeps the count
// - Pre-postscaler match goes to serial port
// - Mode field: off, capture edge choices
// - Compare sets flag, drives pin high/low/none
// - Trigger mode resets Timer1, starts converter
// - Codes 11xx have no PWM action, bits 5:4 stored
// - Capture copies 16-bit Timer1 value
// - Capture sets flag; software clears it
// - New capture overwrites, no overrun flag
// - Edges taken from actual pin level
// - Edge prescaler cleared outside capture modes
// - Prescale change keeps edge counter
// - Compare runs every cycle, same-cycle action
// - Pin routed to port bit 0 or 3
// - Trigger never sets Timer1 overflow flag
// - Timer1 write beats trigger reset
// - Zero control write forces output low
module ccpt_top
(
   input  wire        i_clk,
   input  wire        i_srst,
   input  wire        i_ce,
   input  wire [7:0]  i_addr,
   input  wire [7:0]  i_wdata,
   input  wire        i_wr,
   input  wire        i_rd,
   output reg  [7:0]  o_rdata,
   input  wire [15:0] i_timer1_counter,
   input  wire        i_timer1_wr,
   input  wire        i_timer1_overflow,
   input  wire        i_adc_enabled,
   input  wire        i_capcmp_pin_select,
   input  wire        i_pin_rb0,
   input  wire        i_pin_rb3,
   output reg         o_capcmp_out,
   output reg         o_capcmp_on_rb3,
   output reg         o_timer1_reset,
   output reg         o_adc_start,
   output reg         o_ssp_shift_tick,
   output reg         o_period_match_flag,
   output reg         o_capcmp_event_flag
);

   // ****************************************************
   // Helpers
   // ****************************************************
   function is_capture;
      input [3:0] mode;
      begin
         is_capture = (mode[3:2] == `CCPT_CLASS_CAP);
      end
   endfunction

   function is_compare;
      input [3:0] mode;
      begin
         is_compare = (mode[3:2] == `CCPT_CLASS_CMP);
      end
   endfunction

   // ****************************************************
   // Registers and decode
   // ****************************************************
   reg  [7:0]  flags_q;
   reg  [7:0]  enables_q;
   reg  [7:0]  t2_count_q;
   reg  [7:0]  t2_ctrl_q;
   reg  [7:0]  limit_q;
   reg  [7:0]  cc_ctrl_q;
   reg  [15:0] cc_value_q;
   reg  [3:0]  t2_pre_q;
   reg  [3:0]  t2_post_q;
   reg  [3:0]  edge_cnt_q;
   reg         pin_meta_q;
   reg         pin_sync_q;
   reg         pin_prev_q;
   reg         cmp_match_q;

   wire wr_flags    = i_wr && (i_addr == `CCPT_ADDR_FLAGS);
   wire wr_count    = i_wr && (i_addr == `CCPT_ADDR_T2_COUNT);
   wire wr_t2_ctrl  = i_wr && (i_addr == `CCPT_ADDR_T2_CTRL);
   wire wr_val_low  = i_wr && (i_addr == `CCPT_ADDR_VAL_LOW);
   wire wr_val_high = i_wr && (i_addr == `CCPT_ADDR_VAL_HIGH);
   wire wr_cc_ctrl  = i_wr && (i_addr == `CCPT_ADDR_CC_CTRL);
   wire wr_enables  = i_wr && (i_addr == `CCPT_ADDR_ENABLES);
   wire wr_limit    = i_wr && (i_addr == `CCPT_ADDR_LIMIT);

   wire [3:0] mode   = cc_ctrl_q[3:0];
   wire       t2_run = t2_ctrl_q[`CCPT_T2_RUN];
   wire [1:0] pre_sel =
      t2_ctrl_q[`CCPT_T2_PRE_HI:`CCPT_T2_PRE_LO];
   wire [3:0] post_sel =
      t2_ctrl_q[`CCPT_T2_POST_HI:`CCPT_T2_POST_LO];

   // ****************************************************
   // Period timer
   // ****************************************************
   reg  [3:0] pre_last;
   always @*
   begin
      case (pre_sel)
         `CCPT_PRE_SEL_DIV1: pre_last = `CCPT_PRE_DIV1;
         `CCPT_PRE_SEL_DIV4: pre_last = `CCPT_PRE_DIV4;
         default:            pre_last = `CCPT_PRE_DIV16;
      endcase
   end

   wire t2_tick   = t2_run && (t2_pre_q == pre_last);
   wire t2_match  = t2_tick && (t2_count_q == limit_q);
   wire post_done = t2_match && (t2_post_q == post_sel);
   wire scaler_clr = wr_count || wr_t2_ctrl;

   always @(posedge i_clk)
   begin
      if (i_srst)
      begin
         t2_count_q <= `CCPT_RST_BYTE;
         t2_ctrl_q  <= `CCPT_RST_BYTE;
         limit_q    <= `CCPT_RST_LIMIT;
         t2_pre_q   <= 4'h0;
         t2_post_q  <= 4'h0;
      end
      else if (i_ce)
      begin
         // Count write wins over a coincident increment
         if (wr_count)
            t2_count_q <= i_wdata;
         else if (t2_match)
            t2_count_q <= `CCPT_RST_BYTE;
         else if (t2_tick)
            t2_count_q <= t2_count_q + `CCPT_CNT_ONE8;
         if (wr_t2_ctrl)
            t2_ctrl_q <= i_wdata & `CCPT_T2_CTRL_MASK;
         if (wr_limit)
            limit_q <= i_wdata;
         if (scaler_clr)
         begin
            t2_pre_q  <= 4'h0;
            t2_post_q <= 4'h0;
         end
         else
         begin
            if (t2_tick)
               t2_pre_q <= 4'h0;
            else if (t2_run)
               t2_pre_q <= t2_pre_q + `CCPT_CNT_ONE4;
            if (post_done)
               t2_post_q <= 4'h0;
            else if (t2_match)
               t2_post_q <= t2_post_q + `CCPT_CNT_ONE4;
         end
      end
   end

   // ****************************************************
   // Pin synchroniser and edge detection
   // ****************************************************
   // Mux ahead of the synchroniser so the first stage is read only once
   wire pin_level = i_capcmp_pin_select ? i_pin_rb3 : i_pin_rb0;

   always @(posedge i_clk)
   begin
      if (i_srst)
      begin
         pin_meta_q <= 1'b0;
         pin_sync_q <= 1'b0;
         pin_prev_q <= 1'b0;
      end
      else if (i_ce)
      begin
         pin_meta_q <= pin_level;
         pin_sync_q <= pin_meta_q;
         pin_prev_q <= pin_sync_q;
      end
   end

   wire pin_rise = pin_sync_q && !pin_prev_q;
   wire pin_fall = !pin_sync_q && pin_prev_q;

   // ****************************************************
   // Capture
   // ****************************************************
   reg cap_event;
   always @*
   begin
      case (mode)
         `CCPT_MODE_CAP_FALL: cap_event = pin_fall;
         `CCPT_MODE_CAP_RISE: cap_event = pin_rise;
         `CCPT_MODE_CAP_4TH:
            cap_event = pin_rise &&
                        (edge_cnt_q[1:0] == `CCPT_EDGE_4TH);
         `CCPT_MODE_CAP_16TH:
            cap_event = pin_rise && (edge_cnt_q == `CCPT_EDGE_16TH);
         default:             cap_event = 1'b0;
      endcase
   end

   // Counter is not cleared between prescale settings, so the first
   // capture after a switch may come early
   always @(posedge i_clk)
   begin
      if (i_srst)
         edge_cnt_q <= 4'h0;
      else if (i_ce)
      begin
         if (!is_capture(mode))
            edge_cnt_q <= 4'h0;
         else if (pin_rise)
            edge_cnt_q <= edge_cnt_q + `CCPT_CNT_ONE4;
      end
   end

   // ****************************************************
   // Compare
   // ****************************************************
   wire cmp_match = is_compare(mode) &&
                    (cc_value_q == i_timer1_counter);
   wire trig_pulse = cmp_match && !cmp_match_q &&
                     (mode == `CCPT_MODE_CMP_TRIG);

   always @(posedge i_clk)
   begin
      if (i_srst)
      begin
         cmp_match_q     <= 1'b0;
         o_capcmp_out    <= 1'b0;
         o_capcmp_on_rb3 <= 1'b0;
         o_timer1_reset  <= 1'b0;
         o_adc_start     <= 1'b0;
      end
      else if (i_ce)
      begin
         cmp_match_q     <= cmp_match;
         o_capcmp_on_rb3 <= i_capcmp_pin_select;
         if (wr_cc_ctrl && (i_wdata == `CCPT_RST_BYTE))
            o_capcmp_out <= 1'b0;
         else if (cmp_match && (mode == `CCPT_MODE_CMP_SET))
            o_capcmp_out <= 1'b1;
         else if (cmp_match && (mode == `CCPT_MODE_CMP_CLR))
            o_capcmp_out <= 1'b0;
         // A coincident Timer1 write keeps its value
         o_timer1_reset <= trig_pulse && !i_timer1_wr;
         o_adc_start    <= trig_pulse && i_adc_enabled;
      end
   end

   // ****************************************************
   // Capture/compare control and value
   // ****************************************************
   always @(posedge i_clk)
   begin
      if (i_srst)
      begin
         cc_ctrl_q  <= `CCPT_RST_BYTE;
         cc_value_q <= `CCPT_RST_WORD;
      end
      else if (i_ce)
      begin
         if (wr_cc_ctrl)
            cc_ctrl_q <= i_wdata & `CCPT_CC_CTRL_MASK;
         // Capture wins over a software write in the same cycle
         if (cap_event)
            cc_value_q <= i_timer1_counter;
         else
         begin
            if (wr_val_low)
               cc_value_q[7:0] <= i_wdata;
            if (wr_val_high)
               cc_value_q[15:8] <= i_wdata;
         end
      end
   end

   // ****************************************************
   // Flags and enables
   // ****************************************************
   reg [7:0] flag_set;
   always @*
   begin
      flag_set = 8'h00;
      flag_set[`CCPT_FLAG_PERIOD] = post_done;
      flag_set[`CCPT_FLAG_CAPCMP] = cap_event || cmp_match;
      // Trigger is not routed here by design
      flag_set[`CCPT_FLAG_T1_OVF] = i_timer1_overflow;
   end

   always @(posedge i_clk)
   begin
      if (i_srst)
      begin
         flags_q             <= `CCPT_RST_BYTE;
         enables_q           <= `CCPT_RST_BYTE;
         o_period_match_flag <= 1'b0;
         o_capcmp_event_flag <= 1'b0;
         o_ssp_shift_tick    <= 1'b0;
      end
      else if (i_ce)
      begin
         // Hardware set beats a software clear
         if (wr_flags)
            flags_q <= (i_wdata & `CCPT_FLAGS_MASK) | flag_set;
         else
            flags_q <= flags_q | flag_set;
         if (wr_enables)
            enables_q <= i_wdata & `CCPT_FLAGS_MASK;
         o_period_match_flag <= flags_q[`CCPT_FLAG_PERIOD];
         o_capcmp_event_flag <= flags_q[`CCPT_FLAG_CAPCMP];
         o_ssp_shift_tick    <= t2_match;
      end
   end

   // ****************************************************
   // Read port
   // ****************************************************
   reg [7:0] rd_mux;
   always @*
   begin
      case (i_addr)
         `CCPT_ADDR_FLAGS:    rd_mux = flags_q;
         `CCPT_ADDR_T2_COUNT: rd_mux = t2_count_q;
         `CCPT_ADDR_T2_CTRL:  rd_mux = t2_ctrl_q;
         `CCPT_ADDR_VAL_LOW:  rd_mux = cc_value_q[7:0];
         `CCPT_ADDR_VAL_HIGH: rd_mux = cc_value_q[15:8];
         `CCPT_ADDR_CC_CTRL:  rd_mux = cc_ctrl_q;
         `CCPT_ADDR_ENABLES:  rd_mux = enables_q;
         `CCPT_ADDR_LIMIT:    rd_mux = limit_q;
         default:             rd_mux = 8'h00;
      endcase
   end

   // Data valid only in the cycle after the strobe
   always @(posedge i_clk)
   begin
      if (i_srst)
         o_rdata <= 8'h00;
      else if (i_ce)
         o_rdata <= i_rd ? rd_mux : 8'h00;
   end

endmodule // ccpt_top

// ==== hdl/ccpt_map.vh ====
// Register map, field positions, reset values and mode codes
// Assumes an 8-bit register port and plain-Verilog includers
`ifndef CCPT_MAP_VH
`define CCPT_MAP_VH

// ****************************************************
// Register addresses
// ****************************************************
`define CCPT_ADDR_FLAGS     8'h0c
`define CCPT_ADDR_T2_COUNT  8'h11
`define CCPT_ADDR_T2_CTRL   8'h12
`define CCPT_ADDR_VAL_LOW   8'h15
`define CCPT_ADDR_VAL_HIGH  8'h16
`define CCPT_ADDR_CC_CTRL   8'h17
`define CCPT_ADDR_ENABLES   8'h8c
`define CCPT_ADDR_LIMIT     8'h92

// ****************************************************
// Reset values
// ****************************************************
`define CCPT_RST_BYTE       8'h00
`define CCPT_RST_LIMIT      8'hff
`define CCPT_RST_WORD       16'h0000

// ****************************************************
// Field positions
// ****************************************************
`define CCPT_FLAG_T1_OVF    0
`define CCPT_FLAG_PERIOD    1
`define CCPT_FLAG_CAPCMP    2
`define CCPT_T2_RUN         2
`define CCPT_T2_PRE_HI      1
`define CCPT_T2_PRE_LO      0
`define CCPT_T2_POST_HI     6
`define CCPT_T2_POST_LO     3
`define CCPT_FLAGS_MASK     8'h7f
`define CCPT_T2_CTRL_MASK   8'h7f
`define CCPT_CC_CTRL_MASK   8'h3f

// ****************************************************
// Capture/compare mode codes
// ****************************************************
`define CCPT_MODE_OFF       4'h0
`define CCPT_MODE_CAP_FALL  4'h4
`define CCPT_MODE_CAP_RISE  4'h5
`define CCPT_MODE_CAP_4TH   4'h6
`define CCPT_MODE_CAP_16TH  4'h7
`define CCPT_MODE_CMP_SET   4'h8
`define CCPT_MODE_CMP_CLR   4'h9
`define CCPT_MODE_CMP_SOFT  4'ha
`define CCPT_MODE_CMP_TRIG  4'hb
`define CCPT_CLASS_CAP      2'h1
`define CCPT_CLASS_CMP      2'h2

// ****************************************************
// Prescaler terminal counts
// ****************************************************
`define CCPT_PRE_DIV1       4'h0
`define CCPT_PRE_DIV4       4'h3
`define CCPT_PRE_DIV16      4'hf
`define CCPT_PRE_SEL_DIV1   2'h0
`define CCPT_PRE_SEL_DIV4   2'h1
`define CCPT_EDGE_4TH       2'h3
`define CCPT_EDGE_16TH      4'hf
`define CCPT_CNT_ONE4       4'h1
`define CCPT_CNT_ONE8       8'h01

`endif

// ==== tb/ccpt_monitor.sv ====
// Port-level checker for the period timer and capture/compare top
// Assumes it is bound into ccpt_top, one clock, synchronous reset
`timescale 1ns/100ps
// ****************************************************
// Relations between register port, trigger and flags
// ****************************************************
module ccpt_monitor
(
   input wire       i_clk,
   input wire       i_srst,
   input wire [7:0] i_addr,
   input wire [7:0] i_wdata,
   input wire       i_wr,
   input wire       i_rd,
   input wire [7:0] o_rdata,
   input wire       i_adc_enabled,
   input wire       i_capcmp_pin_select,
   input wire       o_capcmp_out,
   input wire       o_capcmp_on_rb3,
   input wire       o_timer1_reset,
   input wire       o_adc_start,
   input wire       o_ssp_shift_tick,
   input wire       o_period_match_flag,
   input wire       o_capcmp_event_flag
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_srst);
   sequence s_flag_clear_2;
      $past(i_wr && i_addr == 8'h0c, 2);
   endsequence
   sequence s_zero_ctl;
      i_wr && i_addr == 8'h17 && i_wdata == 8'h00;
   endsequence
   property p_rd_idle; !$past(i_rd) |-> o_rdata == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data outside read slot");
   property p_trig_pulse; o_timer1_reset |=> !o_timer1_reset; endproperty
   a_trig_pulse: assert property (p_trig_pulse)
      else $error("trigger longer than one cycle");
   property p_adc_en; o_adc_start |-> $past(i_adc_enabled); endproperty
   a_adc_en: assert property (p_adc_en)
      else $error("conversion start while converter off");
   property p_trig_flag; o_timer1_reset |=> o_capcmp_event_flag; endproperty
   a_trig_flag: assert property (p_trig_flag)
      else $error("trigger without event flag");
   property p_pin_sel;
      !$past(i_srst) |-> o_capcmp_on_rb3 == $past(i_capcmp_pin_select);
   endproperty
   a_pin_sel: assert property (p_pin_sel)
      else $error("pin routing does not follow select");
   property p_zero_ctl; s_zero_ctl |=> !o_capcmp_out; endproperty
   a_zero_ctl: assert property (p_zero_ctl)
      else $error("output latch not cleared by zero control");
   property p_cap_hold; $fell(o_capcmp_event_flag) |-> s_flag_clear_2;
   endproperty
   a_cap_hold: assert property (p_cap_hold)
      else $error("event flag cleared without software write");
   // Flag copy lags the tick by one cycle; software may also set it
   property p_per_flag;
      $rose(o_period_match_flag) |->
         $past(o_ssp_shift_tick) || $past(i_wr && i_addr == 8'h0c, 2);
   endproperty
   a_per_flag: assert property (p_per_flag)
      else $error("period flag without a match");
endmodule // ccpt_monitor

bind ccpt_top ccpt_monitor u_ccpt_monitor (.i_clk, .i_srst, .i_addr,
   .i_wdata, .i_wr, .i_rd, .o_rdata, .i_adc_enabled, .i_capcmp_pin_select,
   .o_capcmp_out, .o_capcmp_on_rb3, .o_timer1_reset, .o_adc_start,
   .o_ssp_shift_tick, .o_period_match_flag, .o_capcmp_event_flag);

// ==== tb/ccpt_t1_model.sv ====
// Far side model: Timer1 counter and the two candidate pins
// Assumes the bench loads, runs or holds the counter
`timescale 1ns/100ps
// ****************************************************
// Timer1 counter and pin levels
// ****************************************************
module ccpt_t1_model
(
   input  wire         i_clk,
   input  wire         i_srst,
   input  wire         i_run,
   input  wire         i_load,
   input  wire  [15:0] i_val,
   input  wire         i_t1_reset,
   input  wire         i_level,
   input  wire         i_sel,
   output logic [15:0] o_count,
   output wire         o_rb0,
   output wire         o_rb3
);
   always @(posedge i_clk)
   begin
      // A coincident software load beats the trigger reset
      if (i_srst)
         o_count <= 16'h0000;
      else if (i_load)
         o_count <= i_val;
      else if (i_t1_reset)
         o_count <= 16'h0000;
      else if (i_run)
         o_count <= o_count + 16'h0001;
   end
   // Unused pin carries the inverse so wrong routing flips edges
   assign o_rb0 = i_sel ? ~i_level : i_level;
   assign o_rb3 = i_sel ? i_level : ~i_level;
endmodule // ccpt_t1_model

// ==== tb/ccpt_top_bench.sv ====
// Self-checking bench: register calls against expected values
// Assumes ccpt_top, the Timer1 model and the bound checker
`timescale 1ns/100ps
// ****************************************************
// Bench top
// ****************************************************
module ccpt_top_bench;
   logic        i_clk = 1'b0, i_srst = 1'b1, i_ce = 1'b1;
   logic        i_wr = 1'b0, i_rd = 1'b0;
   logic        i_timer1_overflow = 1'b0, i_adc_enabled = 1'b0;
   logic        i_capcmp_pin_select = 1'b0, pin_level = 1'b0;
   logic        t1_run = 1'b0, t1_load = 1'b0;
   logic [7:0]  i_addr = 8'h00, i_wdata = 8'h00;
   logic [15:0] t1_val = 16'h0000, cmp_tab = 16'h8a98;
   logic [3:0]  out_tab = 4'b1011;
   wire  [7:0]  o_rdata;
   wire  [15:0] i_timer1_counter;
   wire         i_pin_rb0, i_pin_rb3, o_capcmp_out, o_capcmp_on_rb3;
   wire         o_timer1_reset, o_adc_start, o_ssp_shift_tick;
   wire         o_period_match_flag, o_capcmp_event_flag;
   int          error_cnt = 0, n_compared = 0, n, k, m;
   ccpt_top u_ccpt_top (.i_clk, .i_srst, .i_ce, .i_addr, .i_wdata, .i_wr,
      .i_rd, .o_rdata, .i_timer1_counter, .i_timer1_wr(t1_load),
      .i_timer1_overflow,
      .i_adc_enabled, .i_capcmp_pin_select, .i_pin_rb0, .i_pin_rb3,
      .o_capcmp_out, .o_capcmp_on_rb3, .o_timer1_reset, .o_adc_start,
      .o_ssp_shift_tick, .o_period_match_flag, .o_capcmp_event_flag);
   ccpt_t1_model u_ccpt_t1_model (.i_clk, .i_srst, .i_run(t1_run),
      .i_load(t1_load), .i_val(t1_val), .i_t1_reset(o_timer1_reset),
      .i_level(pin_level), .i_sel(i_capcmp_pin_select),
      .o_count(i_timer1_counter), .o_rb0(i_pin_rb0), .o_rb3(i_pin_rb3));
   always #12.5 i_clk = ~i_clk;
   task automatic stop_test;
      if (error_cnt == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      chk({8'h00, o_rdata}, {8'h00, e});
   endtask
   function automatic logic sig(input int s);
      return s == 0 ? o_capcmp_event_flag :
             s == 1 ? o_timer1_reset : o_ssp_shift_tick;
   endfunction
   // Bounded poll; k holds the cycles waited
   task automatic wait_sig(input int s);
      k = 0;
      do
      begin
         @(posedge i_clk);
         #1;
         k++;
      end
      while (sig(s) !== 1'b1 && k < 400);
      if (sig(s) !== 1'b1)
      begin
         error_cnt++;
         $display("mismatch at %0t: wait ran out", $time);
         stop_test;
      end
   endtask
   task automatic t1_set(input logic [15:0] v, input logic run);
      @(posedge i_clk);
      t1_load <= 1'b1;
      t1_val <= v;
      t1_run <= run;
      @(posedge i_clk);
      t1_load <= 1'b0;
   endtask
   // Six cycles cover the two-flop sync plus edge stage
   task automatic half(input logic lvl);
      @(posedge i_clk);
      pin_level <= lvl;
      repeat (6) @(posedge i_clk);
      #1;
   endtask
   task automatic setm(input logic [3:0] md);
      wr(8'h17, 8'h00);
      wr(8'h17, {4'h0, md});
      wr(8'h0c, 8'h00);
   endtask
   initial
   begin
      repeat (6) @(posedge i_clk);
      i_srst <= 1'b0;
      rd(8'h92, 8'hff);
      rd(8'h11, 8'h00);
      rd(8'h12, 8'h00);
      rd(8'h17, 8'h00);
      rd(8'h0c, 8'h00);
      rd(8'h40, 8'h00);
      wr(8'h8c, 8'h00);
      wr(8'h11, 8'h05);
      wr(8'h12, 8'h7b);
      rd(8'h12, 8'h7b);
      rd(8'h11, 8'h05);
      wr(8'h17, 8'hff);
      rd(8'h17, 8'h3f);
      wr(8'h92, 8'h03);
      wr(8'h11, 8'h00);
      for (m = 0; m < 4; m++)
      begin
         wr(8'h12, {6'h01, m[1:0]});
         wait_sig(2);
         wait_sig(2);
         chk(16'(k), 16'(m == 0 ? 4 : m == 1 ? 16 : 64));
      end
      wr(8'h12, 8'h00);
      wr(8'h0c, 8'h00);
      wr(8'h12, 8'h7c);
      n = 0;
      k = 0;
      do
      begin
         @(posedge i_clk);
         #1;
         n += o_ssp_shift_tick;
         k++;
      end
      while (o_period_match_flag !== 1'b1 && k < 400);
      chk(16'(n), 16'd16);
      chk(o_period_match_flag, 16'h0001);
      wr(8'h12, 8'h00);
      for (m = 4; m < 8; m++)
      begin
         i_capcmp_pin_select <= (m == 4);
         t1_set(16'h0f0f, 1'b0);
         setm(m[3:0]);
         repeat ((m == 6) ? 3 : (m == 7) ? 15 : 0)
         begin
            half(1'b1);
            half(1'b0);
         end
         @(posedge i_clk);
         #1;
         chk(o_capcmp_event_flag, 16'h0000);
         t1_set({12'ha50, m[3:0]}, 1'b0);
         half(1'b1);
         chk(o_capcmp_event_flag, 16'(m != 4));
         half(1'b0);
         chk(o_capcmp_event_flag, 16'h0001);
         rd(8'h15, {4'h0, m[3:0]});
         rd(8'h16, 8'ha5);
      end
      setm(4'h5);
      t1_set(16'h1111, 1'b0);
      half(1'b1);
      t1_set(16'h2222, 1'b0);
      half(1'b0);
      half(1'b1);
      rd(8'h15, 8'h22);
      wr(8'h15, 8'h40);
      wr(8'h16, 8'h00);
      for (m = 0; m < 4; m++)
      begin
         wr(8'h17, {4'h0, cmp_tab[15 - 4 * m -: 4]});
         wr(8'h0c, 8'h00);
         t1_set(16'h003e, 1'b1);
         wait_sig(0);
         chk(o_capcmp_out, 16'(out_tab[m]));
      end
      @(posedge i_clk);
      i_adc_enabled <= 1'b1;
      wr(8'h17, 8'h0b);
      t1_set(16'h003e, 1'b1);
      wait_sig(1);
      chk(o_adc_start, 16'h0001);
      chk(o_capcmp_out, 16'h0001);
      @(posedge i_clk);
      i_adc_enabled <= 1'b0;
      wait_sig(1);
      chk(o_adc_start, 16'h0000);
      // Load lands in the cycle of the next match
      repeat (64) @(posedge i_clk);
      t1_set(16'h1234, 1'b1);
      #1;
      chk(o_timer1_reset, 16'h0000);
      @(posedge i_clk);
      #1;
      chk(i_timer1_counter, 16'h1235);
      rd(8'h0c, 8'h04);
      @(posedge i_clk);
      i_timer1_overflow <= 1'b1;
      @(posedge i_clk);
      i_timer1_overflow <= 1'b0;
      rd(8'h0c, 8'h05);
      wr(8'h17, 8'h00);
      @(posedge i_clk);
      #1;
      chk(o_capcmp_out, 16'h0000);
      stop_test;
   end
endmodule // ccpt_top_bench
